// *** hdl/supply_supervisor_watchdog.sv ***
// Digital core of the supply supervisor with watchdog and memory gating
//
// Overview of operation
// - Processor reset low while supply below threshold or below battery.
// - Reset held at least 140ms (internal) or 35 external ticks after supply becomes valid.
// - Unserviced enabled watchdog pulses reset each period, at least 140ms in internal mode.
// - Active-high reset is always the inverse of active-low reset.
// - Supply-low flag follows threshold comparator with no added delay.
// - Supply-low flag also low while supply is below battery.
// - Floating watchdog input disables watchdog timeouts.
// - Every kick edge, rising or falling, restarts the watchdog count.
// - Watchdog expired output low when kick input constant beyond period.
// - Watchdog expired output set high on kick edge or supply-low.
// - Memory select out follows memory select in when supply valid.
// - Memory select out forced high when supply below threshold.
// - Below battery, early warning output forced low.
// - Backup active high while output switched to battery.
// - Choose high or floating selects internal oscillator timing.
// - Choose low uses external clock counts for reset and watchdog.
// - Internal oscillator reset duration nominally 200ms.
// - Internal mode: time base input selects 1.6s or 100ms period.
// - First watchdog period after any reset is the long period.
// - External clock divided by 64 before clocking the watchdog.
// - Backup mode ignores kick, memory select, time base inputs.
`timescale 1ns/100ps
`include "sswd_cfg.svh"
module supply_supervisor_watchdog #(
  parameter bit SHORT_WHEN_HIGH = 1'b1
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic supplyBelowThreshold,
  input  wire logic supplyBelowBattery,
  input  wire logic earlyWarnSense,
  input  wire logic watchdogKickIn,
  input  wire logic watchdogKickFloating,
  input  wire logic memSelectInN,
  input  wire logic timebaseIn,
  input  wire logic timebaseChoose,
  output logic      processorResetN,
  output logic      processorReset,
  output logic      supplyLowFlag,
  output logic      watchdogExpiredN,
  output logic      earlyWarnOutN,
  output logic      backupActive,
  output logic      memSelectOutN
);

  localparam int INT_RESET_TICKS = `SSWD_RESET_NOM_MS * 1000 / `SSWD_TICK_US;
  localparam int INT_LONG_TICKS  = `SSWD_WD_LONG_MS * 1000 / `SSWD_TICK_US;
  localparam int INT_SHORT_TICKS = `SSWD_WD_SHORT_MS * 1000 / `SSWD_TICK_US;
  localparam int CW              = `SSWD_COUNT_W;
  // Supply bad but not backup, so release shows no false backup flag
  localparam logic [7:0] SYNC_RESET = `SSWD_SYNC_RESET;

  // *****************************************
  // Reset release and pin synchronisers
  // *****************************************
  logic       rstMeta;
  logic       rst_n;
  logic [7:0] pinRaw;
  logic [7:0] syncA;
  logic [7:0] syncB;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rst_n   <= rstMeta;
    end
  end

  // Pins gathered in one word, bit order fixed by the taps below
  assign pinRaw = {timebaseChoose, timebaseIn, memSelectInN, watchdogKickFloating,
                   watchdogKickIn, earlyWarnSense, supplyBelowBattery, supplyBelowThreshold};

  // Unsynchronised paths would let one comparator glitch split across users
  for (genvar i = 0; i < 8; i++) begin : g_sync
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        syncA[i] <= SYNC_RESET[i];
        syncB[i] <= SYNC_RESET[i];
      end else begin
        syncA[i] <= pinRaw[i];
        syncB[i] <= syncA[i];
      end
    end
  end

  logic belowThr;
  logic belowBatt;
  logic warnSense;
  logic kickLevel;
  logic kickFloat;
  logic memSelIn;
  logic tbIn;
  logic tbChoose;
  assign belowThr  = syncB[0];
  assign belowBatt = syncB[1];
  assign warnSense = syncB[2];
  assign kickLevel = syncB[3];
  assign kickFloat = syncB[4];
  assign memSelIn  = syncB[5];
  assign tbIn      = syncB[6];
  assign tbChoose  = syncB[7];

  logic supplyBad;
  assign supplyBad = belowThr | belowBatt;

  // *****************************************
  // Time base selection
  // *****************************************
  logic useExternal;
  logic shortSelect;
  logic tick;

  // Choose held latched during backup so a dying pin cannot flip the mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      useExternal <= 1'b0;
      shortSelect <= 1'b0;
    end else if (!belowBatt) begin
      useExternal <= !tbChoose;
      // External base has no spare select pin, so it runs short after the first period
      shortSelect <= !tbChoose || (tbIn == SHORT_WHEN_HIGH);
    end
  end

  sswd_tick_gen timeBase (
    .clock       (clock),
    .rst_n       (rst_n),
    .useExternal (useExternal),
    .extClock    (tbIn),
    .freeze      (belowBatt),
    .tick        (tick)
  );

  // *****************************************
  // Time counts of the selected base
  // *****************************************
  // One selector for all three times keeps reset and watchdog on the same base
  function automatic logic [CW-1:0] pick_ticks(input logic ext, input int extTicks,
                                               input int intTicks);
    return ext ? CW'(extTicks) : CW'(intTicks);
  endfunction

  logic [CW-1:0] resetTicks;
  logic [CW-1:0] longTicks;
  logic [CW-1:0] shortTicks;
  assign resetTicks = pick_ticks(useExternal, `SSWD_EXT_RESET_TICKS, INT_RESET_TICKS);
  assign longTicks  = pick_ticks(useExternal, `SSWD_EXT_WD_LONG_TICKS, INT_LONG_TICKS);
  assign shortTicks = pick_ticks(useExternal, `SSWD_EXT_WD_SHORT_TICKS, INT_SHORT_TICKS);

  // *****************************************
  // Kick edge detection
  // *****************************************
  logic kickLast;
  logic kickEdge;

  // Reset copy matches the low idle level of the pin, so release shows no false edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kickLast <= 1'b0;
    end else begin
      kickLast <= kickLevel;
    end
  end

  assign kickEdge = (kickLevel != kickLast) && !kickFloat && !belowBatt;

  // *****************************************
  // Reset pulse generator
  // *****************************************
  sswd_pkg::sswd_reset_state_type state;
  logic [CW-1:0] holdCount;
  logic          wdTimeout;
  logic          firstPeriod;

  // Reset time comes from the time base: 200ms internally, 35 ticks of the divided external clock otherwise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state     <= sswd_pkg::SSWD_RESET_HOLD;
      holdCount <= '0;
    end else begin
      case (state)
        sswd_pkg::SSWD_RESET_HOLD: begin
          if (supplyBad) begin
            holdCount <= '0;
          end else if (tick) begin
            if (holdCount >= resetTicks - CW'(1)) begin
              holdCount <= '0;
              state     <= sswd_pkg::SSWD_RUN;
            end else begin
              holdCount <= holdCount + CW'(1);
            end
          end
        end
        default: begin
          if (supplyBad || wdTimeout) begin
            holdCount <= '0;
            state     <= sswd_pkg::SSWD_RESET_HOLD;
          end
        end
      endcase
    end
  end

  // *****************************************
  // Watchdog counter
  // *****************************************
  logic [CW-1:0] wdCount;
  logic [CW-1:0] wdLimit;
  assign wdLimit   = (firstPeriod || !shortSelect) ? longTicks : shortTicks;
  assign wdTimeout = (state == sswd_pkg::SSWD_RUN) && !kickFloat && tick &&
                     (wdCount >= wdLimit - CW'(1));

  // Floating pin holds the count at zero and ends the first period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wdCount     <= '0;
      firstPeriod <= 1'b1;
    end else if (state != sswd_pkg::SSWD_RUN) begin
      wdCount     <= '0;
      firstPeriod <= 1'b1;
    end else if (kickEdge || kickFloat) begin
      wdCount     <= '0;
      firstPeriod <= 1'b0;
    end else if (tick) begin
      wdCount <= wdCount + CW'(1);
    end
  end

  // *****************************************
  // Outputs
  // *****************************************
  logic next_resetActive;
  assign next_resetActive = supplyBad || wdTimeout || state != sswd_pkg::SSWD_RUN;

  // Both copies come from the same next value so they never disagree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      processorResetN <= 1'b0;
    end else begin
      processorResetN <= !next_resetActive;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      processorReset <= 1'b1;
    end else begin
      processorReset <= next_resetActive;
    end
  end

  // A kick in the same cycle as a timeout wins for this flag only; reset still fires, the count restarts anyway
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      watchdogExpiredN <= 1'b1;
    end else if (supplyBad || kickEdge) begin
      watchdogExpiredN <= 1'b1;
    end else if (wdTimeout) begin
      watchdogExpiredN <= 1'b0;
    end
  end

  // Direct from the synchronised comparators, no timer in the path
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      supplyLowFlag <= 1'b0;
    end else begin
      supplyLowFlag <= !supplyBad;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      earlyWarnOutN <= 1'b0;
    end else begin
      earlyWarnOutN <= belowBatt ? 1'b0 : warnSense;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      backupActive <= 1'b0;
    end else begin
      backupActive <= belowBatt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      memSelectOutN <= 1'b1;
    end else begin
      memSelectOutN <= supplyBad ? 1'b1 : memSelIn;
    end
  end

endmodule

// *** common/sswd_cfg.svh ***
// Timing and configuration constants of the supply supervisor core
`ifndef SSWD_CFG_SVH
`define SSWD_CFG_SVH

// *****************************************
// Clock and internal time base
// *****************************************
`define SSWD_CLOCK_HZ          100000000
`define SSWD_TICK_US           1000
`define SSWD_TICK_CYCLES       ((`SSWD_CLOCK_HZ / 1000000) * `SSWD_TICK_US)

// *****************************************
// Times in milliseconds
// *****************************************
`define SSWD_RESET_MIN_MS      140
`define SSWD_RESET_NOM_MS      200
`define SSWD_WD_LONG_MS        1600
`define SSWD_WD_SHORT_MS       100

// *****************************************
// External clock mode
// *****************************************
`define SSWD_EXT_DIVIDE        64
`define SSWD_EXT_RESET_TICKS   35
`define SSWD_EXT_WD_LONG_TICKS 400
`define SSWD_EXT_WD_SHORT_TICKS 25

`define SSWD_COUNT_W           16

// *****************************************
// Reset values
// *****************************************
// Synchronisers start at supply bad only, never at backup
`define SSWD_SYNC_RESET        8'h01

`endif

// *** common/sswd_pkg.sv ***
// Types of the supply supervisor core
package sswd_pkg;

  typedef enum logic [1:0] {
    SSWD_RESET_HOLD,
    SSWD_RUN
  } sswd_reset_state_type;

endpackage

// *** hdl/sswd_tick_gen.sv ***
// Time base: internal millisecond ticks or external clock divided by 64
`timescale 1ns/100ps
`include "sswd_cfg.svh"
module sswd_tick_gen (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic useExternal,
  input  wire logic extClock,
  input  wire logic freeze,
  output logic      tick
);

  localparam int INT_CYCLES = `SSWD_TICK_CYCLES;
  localparam int EXT_DIV    = `SSWD_EXT_DIVIDE;

  logic [16:0] intCount;
  logic [5:0]  extCount;
  logic        extLast;

  // *****************************************
  // Dividers
  // *****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      intCount <= 17'h0;
      extCount <= 6'h0;
      extLast  <= 1'b0;
      tick     <= 1'b0;
    end else begin
      extLast <= extClock;
      tick    <= 1'b0;
      if (freeze) begin
        intCount <= 17'h0;
      end else if (!useExternal) begin
        if (intCount == 17'(INT_CYCLES - 1)) begin
          intCount <= 17'h0;
          tick     <= 1'b1;
        end else begin
          intCount <= intCount + 17'h1;
        end
      end else if (extClock && !extLast) begin
        // Phase of the divide is free running: up to one tick of jitter
        if (extCount == 6'(EXT_DIV - 1)) begin
          extCount <= 6'h0;
          tick     <= 1'b1;
        end else begin
          extCount <= extCount + 6'h1;
        end
      end
    end
  end

endmodule

// *** tb/sswd_checker_asserts.sv ***
// Assertion checker of the supply supervisor core
`timescale 1ns/100ps
`include "sswd_cfg.svh"
module sswd_checker (
  input logic clock,
  input logic resetn,
  input logic supplyBelowThreshold,
  input logic supplyBelowBattery,
  input logic watchdogKickIn,
  input logic watchdogKickFloating,
  input logic memSelectInN,
  input logic processorResetN,
  input logic processorReset,
  input logic supplyLowFlag,
  input logic watchdogExpiredN,
  input logic earlyWarnOutN,
  input logic backupActive,
  input logic memSelectOutN
);
  // ****
  // Hold counter
  // ****
  // Fastest time base the input sync can follow is half the clock
  localparam int minHold = (`SSWD_EXT_RESET_TICKS - 1) * `SSWD_EXT_DIVIDE * 2;
  int lowCount;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lowCount <= 0;
    end else begin
      lowCount <= processorResetN ? 0 : lowCount + 1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ****
  // Properties
  // ****
  property p_inv;
    processorReset == !processorResetN;
  endproperty
  a_inv: assert property (p_inv) else $error("reset outputs not inverse");
  property p_below;
    supplyBelowThreshold [*4] |-> !processorResetN && memSelectOutN && !supplyLowFlag;
  endproperty
  a_below: assert property (p_below) else $error("low supply not seen");
  property p_good;
    (!supplyBelowThreshold && !supplyBelowBattery) [*6] |-> supplyLowFlag;
  endproperty
  a_good: assert property (p_good) else $error("flag not back high");
  property p_backup;
    supplyBelowBattery [*6] |-> backupActive && !earlyWarnOutN && !supplyLowFlag && memSelectOutN;
  endproperty
  a_backup: assert property (p_backup) else $error("backup state wrong");
  property p_follow;
    (!supplyBelowThreshold && !supplyBelowBattery && $stable(memSelectInN)) [*6]
      |-> memSelectOutN == memSelectInN;
  endproperty
  a_follow: assert property (p_follow) else $error("select not passed");
  property p_kick;
    $changed(watchdogKickIn) && !watchdogKickFloating && !supplyBelowBattery
      |-> ##3 watchdogExpiredN;
  endproperty
  a_kick: assert property (p_kick) else $error("kick did not clear");
  property p_timeout;
    $fell(watchdogExpiredN) |-> ##[0:2] !processorResetN;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout without reset");
  property p_float;
    $fell(watchdogExpiredN) |-> !$past(watchdogKickFloating, 3);
  endproperty
  a_float: assert property (p_float) else $error("timeout while disabled");
  property p_hold;
    $rose(processorResetN) |-> lowCount >= minHold;
  endproperty
  a_hold: assert property (p_hold) else $error("reset pulse too short");
  c_timeout: cover property ($fell(watchdogExpiredN));
  c_backup: cover property ($rose(backupActive));
  c_release: cover property ($rose(processorResetN));
endmodule
bind supply_supervisor_watchdog sswd_checker checker0 (
  .clock                (clock),
  .resetn               (resetn),
  .supplyBelowThreshold (supplyBelowThreshold),
  .supplyBelowBattery   (supplyBelowBattery),
  .watchdogKickIn       (watchdogKickIn),
  .watchdogKickFloating (watchdogKickFloating),
  .memSelectInN         (memSelectInN),
  .processorResetN      (processorResetN),
  .processorReset       (processorReset),
  .supplyLowFlag        (supplyLowFlag),
  .watchdogExpiredN     (watchdogExpiredN),
  .earlyWarnOutN        (earlyWarnOutN),
  .backupActive         (backupActive),
  .memSelectOutN        (memSelectOutN)
);

// *** tb/sswd_cpu_model.sv ***
// Processor model that services the watchdog and feeds the time base
`timescale 1ns/100ps
module sswd_cpu_model (
  input  logic clock,
  input  logic kickRequest,
  input  logic extClockOn,
  output logic watchdogKickIn = 1'b0,
  output logic timebaseIn = 1'b1
);
  // ****
  // Drivers
  // ****
  // Flipping the level gives rising and falling kicks alike
  always @(posedge clock) begin
    if (kickRequest) begin
      watchdogKickIn <= !watchdogKickIn;
    end
  end
  // Idle time base sits at its pull-up level
  always @(posedge clock) begin
    timebaseIn <= extClockOn ? !timebaseIn : 1'b1;
  end
endmodule

// *** tb/test_supply_supervisor_watchdog.sv ***
// Testbench of the supply supervisor core
`timescale 1ns/100ps
module test_supply_supervisor_watchdog;
  logic clock = 1'b0;
  logic resetn = 1'b1;
  logic supplyBelowThreshold = 1'b1;
  logic supplyBelowBattery = 1'b0;
  logic earlyWarnSense = 1'b1;
  logic watchdogKickFloating = 1'b0;
  logic memSelectInN = 1'b0;
  logic timebaseChoose = 1'b0;
  logic kickRequest = 1'b0;
  logic extClockOn = 1'b1;
  logic watchdogKickIn, timebaseIn, processorResetN, processorReset;
  logic supplyLowFlag, watchdogExpiredN, earlyWarnOutN, backupActive, memSelectOutN;
  int   mismatches = 0;
  int   comparisons = 0;
  int   n;
  supply_supervisor_watchdog dut (
    .clock                (clock),
    .resetn               (resetn),
    .supplyBelowThreshold (supplyBelowThreshold),
    .supplyBelowBattery   (supplyBelowBattery),
    .earlyWarnSense       (earlyWarnSense),
    .watchdogKickIn       (watchdogKickIn),
    .watchdogKickFloating (watchdogKickFloating),
    .memSelectInN         (memSelectInN),
    .timebaseIn           (timebaseIn),
    .timebaseChoose       (timebaseChoose),
    .processorResetN      (processorResetN),
    .processorReset       (processorReset),
    .supplyLowFlag        (supplyLowFlag),
    .watchdogExpiredN     (watchdogExpiredN),
    .earlyWarnOutN        (earlyWarnOutN),
    .backupActive         (backupActive),
    .memSelectOutN        (memSelectOutN)
  );
  sswd_cpu_model cpu (
    .clock          (clock),
    .kickRequest    (kickRequest),
    .extClockOn     (extClockOn),
    .watchdogKickIn (watchdogKickIn),
    .timebaseIn     (timebaseIn)
  );
  always #5 clock = !clock;
  // ****
  // Helpers
  // ****
  task automatic ticks(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic check(input string what, input logic expected, input logic seen);
    comparisons++;
    if (seen !== expected) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", what, expected, seen);
    end
  endtask
  task automatic span(input string what, input int expected, input int seen);
    comparisons++;
    // One divider period of phase jitter either way
    if (seen < expected - 140 || seen > expected + 140) begin
      mismatches++;
      $display("mismatch %s expected %0d seen %0d", what, expected, seen);
    end
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic kick;
    kickRequest <= 1'b1;
    ticks(1);
    kickRequest <= 1'b0;
    ticks(4);
  endtask
  task automatic wait_release;
    n = 0;
    while (processorResetN !== 1'b1 && n < 20000) begin
      ticks(1);
      n++;
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_gating;
    supplyBelowThreshold <= 1'b0;
    ticks(8);
    check("memSelectOutN", 1'b0, memSelectOutN);
    supplyBelowThreshold <= 1'b1;
    ticks(4);
    check("supplyLowFlag", 1'b0, supplyLowFlag);
    check("memSelectOutN", 1'b1, memSelectOutN);
    check("processorReset", 1'b1, processorReset);
    supplyBelowThreshold <= 1'b0;
    ticks(4);
    check("supplyLowFlag", 1'b1, supplyLowFlag);
  endtask
  task automatic t_backup;
    supplyBelowBattery <= 1'b1;
    ticks(4);
    check("backupActive", 1'b1, backupActive);
    check("earlyWarnOutN", 1'b0, earlyWarnOutN);
    check("supplyLowFlag", 1'b0, supplyLowFlag);
    check("memSelectOutN", 1'b1, memSelectOutN);
    supplyBelowBattery <= 1'b0;
    ticks(4);
    check("backupActive", 1'b0, backupActive);
    wait_release();
    span("reset hold", 4480, n);
  endtask
  task automatic t_timeout;
    n = 0;
    while (watchdogExpiredN !== 1'b0 && n < 60000) begin
      ticks(1);
      n++;
    end
    span("first period", 51200, n);
    ticks(2);
    check("processorResetN", 1'b0, processorResetN);
    kick();
    check("watchdogExpiredN", 1'b1, watchdogExpiredN);
    wait_release();
  endtask
  task automatic t_service;
    // Kick spacing stays under the shortest short period of 24 full ticks
    for (int i = 0; i < 4; i++) begin
      ticks(3000);
      check("watchdogExpiredN", 1'b1, watchdogExpiredN);
      kick();
    end
    watchdogKickFloating <= 1'b1;
    ticks(4000);
    check("watchdogExpiredN", 1'b1, watchdogExpiredN);
    watchdogKickFloating <= 1'b0;
    ticks(1000);
    check("processorResetN", 1'b1, processorResetN);
    // Short period of 25 ticks of 128 cycles, less the 1000 already waited
    n = 0;
    while (watchdogExpiredN !== 1'b0 && n < 5000) begin
      ticks(1);
      n++;
    end
    span("short period", 2200, n);
  endtask
  initial begin
    resetn <= 1'b0;
    ticks(2);
    resetn <= 1'b1;
    check("processorReset", 1'b1, processorReset);
    t_gating();
    t_backup();
    t_timeout();
    t_service();
    give_verdict();
  end
  initial begin
    ticks(90000);
    mismatches++;
    give_verdict();
  end
endmodule
